// [src/ipca_pkg.sv]
package ipca_pkg;

   // =====================================================================
   // register map (byte addresses, one aligned word each)
   localparam logic [4:0] IPCA_OFS_MASK = 5'h00;
   localparam logic [4:0] IPCA_OFS_TRIGGER = 5'h04;
   localparam logic [4:0] IPCA_OFS_VECTOR_BASE = 5'h08;
   localparam logic [4:0] IPCA_OFS_PENDING = 5'h0c;
   localparam logic [4:0] IPCA_OFS_SERVICE = 5'h10;
   localparam logic [4:0] IPCA_OFS_DONE = 5'h14;
   localparam logic [4:0] IPCA_OFS_STATUS = 5'h18;

   // =====================================================================
   // reset values and field layout
   localparam logic [7:0] IPCA_RST_MASK = 8'hff;
   localparam logic [7:0] IPCA_RST_TRIGGER = 8'h00;
   localparam logic [7:0] IPCA_RST_VECTOR_BASE = 8'h00;
   localparam int IPCA_BASE_LSB = 3;
   localparam logic [2:0] IPCA_SPURIOUS_LEVEL = 3'h7;

   // =====================================================================
   // bus answers
   localparam logic [1:0] IPCA_RESP_OKAY = 2'h0;
   localparam logic [1:0] IPCA_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FIRST,
      ST_GAP,
      ST_SECOND
   } ipca_state_t;

   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] level_mode;
      logic [7:0] vector_base;
   } ipca_cfg_t;

endpackage

// [src/ipca_top.sv]
`timescale 1ns/1ps
module ipca_top
   import ipca_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic [7:0] REQUEST_INPUTS,
   input wire logic ACKNOWLEDGE_PULSE,
   output logic CPU_MASKABLE_REQUEST_PIN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   // =====================================================================
   // input synchronisers: bit 8 is the acknowledge pulse
   logic [8:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
   logic [7:0] in_f;
   logic ack_f, ack_prev_reg, ack_rise, ack_fall;

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         sync1_reg <= 9'h000;
         sync2_reg <= 9'h000;
         sync3_reg <= 9'h000;
         filt_reg <= 9'h000;
         ack_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= {ACKNOWLEDGE_PULSE, REQUEST_INPUTS};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         // a level counts only once stages two and three agree
         filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
         ack_prev_reg <= filt_reg[8];
      end
   end

   assign in_f = filt_reg[7:0];
   assign ack_f = filt_reg[8];
   // acknowledge has no chip-select qualifier at all
   assign ack_rise = ack_f & ~ack_prev_reg;
   assign ack_fall = ~ack_f & ack_prev_reg;

   // =====================================================================
   // acknowledge sequence
   ipca_state_t state_reg, state_next;
   ipca_cfg_t cfg_reg;
   logic [7:0] edge_reg, req_reg, service_reg, cand, allowed, edge_next, req_next;
   logic [7:0] commit_bits, done_bits, service_next;
   logic [2:0] grant_reg, best;
   logic spur_reg, frozen, commit, any_req, done_wr;

   function automatic logic [2:0] lowest_set(input logic [7:0] v);
      logic [2:0] r;
      r = IPCA_SPURIOUS_LEVEL;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = i[2:0];
         end
      end
      return r;
   endfunction

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (ack_rise) begin
               state_next = ST_FIRST;
            end
         end
         ST_FIRST: begin
            if (ack_fall) begin
               state_next = ST_GAP;
            end
         end
         ST_GAP: begin
            if (ack_rise) begin
               state_next = ST_SECOND;
            end
         end
         ST_SECOND: begin
            if (ack_fall) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   assign frozen = (state_reg != ST_IDLE);
   // service bit is set as the second pulse ends
   assign commit = (state_reg == ST_SECOND) & ack_fall & ~spur_reg;
   assign commit_bits = commit ? (8'h01 << grant_reg) : 8'h00;

   // =====================================================================
   // eight priority cells, level 0 the most urgent
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_cell
         // low input arms; granting disarms, and the disarm wins
         assign edge_next[g] = ~commit_bits[g] & (edge_reg[g] | ~in_f[g]);
         // edge mode needs an armed latch, level mode only the level
         assign req_next[g] = frozen ? req_reg[g]
                              : (in_f[g] & (cfg_reg.level_mode[g] | edge_reg[g]));
         // a level may interrupt only if nothing as urgent is in service
         assign allowed[g] = ~|service_reg[g:0];
      end
   endgenerate

   assign cand = req_reg & ~cfg_reg.mask & allowed;
   assign any_req = |cand;
   assign best = lowest_set(cand);
   // hardware set beats a same-cycle software clear
   assign service_next = (service_reg & ~done_bits) | commit_bits;

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         state_reg <= ST_IDLE;
         edge_reg <= 8'h00;
         req_reg <= 8'h00;
         service_reg <= 8'h00;
         grant_reg <= 3'h0;
         spur_reg <= 1'b0;
         DATA_OUT <= 8'h00;
         DATA_OE <= 1'b0;
         CPU_MASKABLE_REQUEST_PIN <= 1'b0;
      end else begin
         state_reg <= state_next;
         edge_reg <= edge_next;
         req_reg <= req_next;
         service_reg <= service_next;
         CPU_MASKABLE_REQUEST_PIN <= any_req;
         if ((state_reg == ST_GAP) && ack_rise) begin
            // resolved again now; nothing left gives the spurious level
            grant_reg <= best;
            spur_reg <= ~any_req;
            DATA_OUT <= {cfg_reg.vector_base[7:IPCA_BASE_LSB], best};
            DATA_OE <= 1'b1;
         end else if (state_reg != ST_SECOND || ack_fall) begin
            DATA_OE <= 1'b0;
         end
      end
   end

   // =====================================================================
   // AXI4-Lite slave: address and data accepted in either order
   logic aw_ok_reg, w_ok_reg, aw_ok_next, w_ok_next, bvalid_next, rvalid_next;
   logic aw_hs, w_hs, ar_hs, do_wr;
   logic [4:0] waddr_reg;
   logic [31:0] wdata_reg, rd_word;
   logic [3:0] wstrb_reg;
   logic wr_map, rd_map, wr_lane0;
   logic [4:0] raddr;

   assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
   assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
   assign do_wr = aw_ok_reg & w_ok_reg;
   assign aw_ok_next = (aw_ok_reg | aw_hs) & ~do_wr;
   assign w_ok_next = (w_ok_reg | w_hs) & ~do_wr;
   assign bvalid_next = do_wr | (S_AXI_BVALID & ~S_AXI_BREADY);
   assign rvalid_next = ar_hs | (S_AXI_RVALID & ~S_AXI_RREADY);
   assign wr_lane0 = do_wr & wstrb_reg[0];
   assign wr_map = (waddr_reg <= IPCA_OFS_STATUS) & (waddr_reg[1:0] == 2'h0);
   assign done_wr = wr_lane0 & (waddr_reg == IPCA_OFS_DONE);
   assign done_bits = done_wr ? wdata_reg[7:0] : 8'h00;
   assign raddr = S_AXI_ARADDR[4:0];
   assign rd_map = (S_AXI_ARADDR[31:5] == 27'h0) & (raddr <= IPCA_OFS_STATUS) & (raddr[1:0] == 2'h0);

   always_comb begin
      rd_word = 32'h0;
      unique case (raddr)
         IPCA_OFS_MASK: rd_word[7:0] = cfg_reg.mask;
         IPCA_OFS_TRIGGER: rd_word[7:0] = cfg_reg.level_mode;
         IPCA_OFS_VECTOR_BASE: rd_word[7:0] = cfg_reg.vector_base;
         IPCA_OFS_PENDING: rd_word[7:0] = req_reg;
         IPCA_OFS_SERVICE: rd_word[7:0] = service_reg;
         IPCA_OFS_STATUS: rd_word[3:0] = {DATA_OE, frozen, spur_reg, CPU_MASKABLE_REQUEST_PIN};
         default: rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         aw_ok_reg <= 1'b0;
         w_ok_reg <= 1'b0;
         waddr_reg <= 5'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= IPCA_RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= IPCA_RESP_OKAY;
         cfg_reg <= '{IPCA_RST_MASK, IPCA_RST_TRIGGER, IPCA_RST_VECTOR_BASE};
      end else begin
         aw_ok_reg <= aw_ok_next;
         w_ok_reg <= w_ok_next;
         S_AXI_AWREADY <= ~aw_ok_next & ~bvalid_next;
         S_AXI_WREADY <= ~w_ok_next & ~bvalid_next;
         S_AXI_BVALID <= bvalid_next;
         S_AXI_ARREADY <= ~rvalid_next;
         S_AXI_RVALID <= rvalid_next;
         if (aw_hs) begin
            waddr_reg <= (S_AXI_AWADDR[31:5] == 27'h0) ? S_AXI_AWADDR[4:0] : 5'h1f;
         end
         if (w_hs) begin
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
         end
         if (do_wr) begin
            S_AXI_BRESP <= wr_map ? IPCA_RESP_OKAY : IPCA_RESP_SLVERR;
         end
         if (wr_lane0 && waddr_reg == IPCA_OFS_MASK) begin
            cfg_reg.mask <= wdata_reg[7:0];
         end
         if (wr_lane0 && waddr_reg == IPCA_OFS_TRIGGER) begin
            cfg_reg.level_mode <= wdata_reg[7:0];
         end
         if (wr_lane0 && waddr_reg == IPCA_OFS_VECTOR_BASE) begin
            cfg_reg.vector_base <= wdata_reg[7:0];
         end
         if (ar_hs) begin
            S_AXI_RDATA <= rd_map ? rd_word : 32'h0;
            S_AXI_RRESP <= rd_map ? IPCA_RESP_OKAY : IPCA_RESP_SLVERR;
         end
      end
   end

   // =====================================================================
   // assertions
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   sequence s_second_start;
      (state_reg == ST_GAP) && ack_rise;
   endsequence

   sequence s_second_end;
      commit;
   endsequence

   a_masked_no_req: assert property (((req_reg & ~cfg_reg.mask) == 8'h00) |=> !CPU_MASKABLE_REQUEST_PIN)
      else $error("masked request reached the processor");
   a_lone_request: assert property (((req_reg & ~cfg_reg.mask) != 8'h00 && service_reg == 8'h00)
      |=> CPU_MASKABLE_REQUEST_PIN)
      else $error("lone request did not raise the request pin");
   a_first_quiet: assert property ((state_reg == ST_FIRST) |-> !DATA_OE)
      else $error("bus driven during first acknowledge");
   a_vector_byte: assert property (s_second_start ##1 1'b1 |-> DATA_OE
      && DATA_OUT == {cfg_reg.vector_base[7:IPCA_BASE_LSB], $past(best)})
      else $error("wrong vector byte on second acknowledge");
   a_latch_frozen: assert property ((frozen && $past(frozen)) |-> $stable(req_reg))
      else $error("request latch moved during acknowledge");
   a_service_set: assert property (s_second_end |=> service_reg[$past(grant_reg)] && !edge_reg[$past(grant_reg)]
      && !DATA_OE)
      else $error("grant not recorded after acknowledge");
   a_edge_armed: assert property ((commit_bits == 8'h00) |=> ((~$past(in_f) & ~edge_reg) == 8'h00))
      else $error("low input left edge latch clear");
   a_level_follow: assert property (!frozen |=> ((req_reg ^ $past(in_f)) & $past(cfg_reg.level_mode)) == 8'h00)
      else $error("level cell did not follow its input");
   a_service_hold: assert property (!done_wr |=> (($past(service_reg) & ~service_reg) == 8'h00))
      else $error("service bit fell without a command");

endmodule // ipca_top

// [verification/ipca_cpu_model.sv]
`timescale 1ns/1ps
// =====================================================================
// processor side: gives acknowledge pulses when a test calls ack_seq, without watching the request pin
module ipca_cpu_model (
   input wire logic clk,
   input wire logic [7:0] data_in,
   input wire logic data_oe,
   output logic ack,
   output logic lock_n,
   output logic oe_first,
   output logic [9:0] table_addr
);
   initial begin
      ack = 1'b0;
      lock_n = 1'b1;
      oe_first = 1'b0;
      table_addr = 10'h000;
   end
   // w sets pulse and gap length; a long tail lets the block commit before the bus lock drops
   task automatic ack_seq(input int w);
      int i;
      oe_first = 1'b0;
      // a vector left from an earlier sequence must not satisfy a later check
      table_addr <= 10'h000;
      lock_n <= 1'b0;
      for (i = 0; i < 5 * w; i++) begin
         ack <= (i < w) || (i >= 2 * w && i < 3 * w);
         @(negedge clk);
         if (i < 2 * w && data_oe) oe_first = 1'b1;
         if (i >= 2 * w && data_oe) table_addr <= {data_in, 2'b00};
         @(posedge clk);
      end
      lock_n <= 1'b1;
   endtask
endmodule // ipca_cpu_model

// [verification/interrupt_priority_cell_ack_tb_top.sv]
`timescale 1ns/1ps
module interrupt_priority_cell_ack_tb_top import ipca_pkg::*;;
   logic SYS_CLK = 1'b0;
   logic SRST = 1'b1;
   logic [7:0] REQUEST_INPUTS = 8'h00;
   logic ACKNOWLEDGE_PULSE, CPU_MASKABLE_REQUEST_PIN, DATA_OE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_ARREADY, S_AXI_RVALID, lock_n, oe_first;
   logic [7:0] DATA_OUT;
   logic [9:0] table_addr;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [31:0] S_AXI_RDATA;
   logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   // answer readies stay high, so back-to-back calls never drive them twice in one step
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b1, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b1;
   int err_count = 0;
   int total_checks = 0;
   always #4 SYS_CLK = ~SYS_CLK;
   ipca_top dut_u (.SYS_CLK, .SRST, .REQUEST_INPUTS, .ACKNOWLEDGE_PULSE, .CPU_MASKABLE_REQUEST_PIN, .DATA_OUT,
      .DATA_OE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
      .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
      .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
   ipca_cpu_model cpu_u (.clk(SYS_CLK), .data_in(DATA_OUT), .data_oe(DATA_OE), .ack(ACKNOWLEDGE_PULSE), .lock_n,
      .oe_first, .table_addr);
   // =====================================================================
   // helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         $display("MISMATCH at %0t ns: %s got %h expected %h", $time, what, got, exp);
         err_count++;
      end
   endtask
   function automatic logic [31:0] vaddr(input logic [7:0] base, input logic [2:0] lvl);
      return {22'h0, base[7:3], lvl, 2'b00};
   endfunction
   // ready, valid and data are sampled at the falling edge, so the rising edge never races
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      do begin
         @(negedge SYS_CLK);
         ta = S_AXI_AWVALID && S_AXI_AWREADY;
         tw = S_AXI_WVALID && S_AXI_WREADY;
         tb = S_AXI_BVALID;
         r = S_AXI_BRESP;
         @(posedge SYS_CLK);
         if (ta) S_AXI_AWVALID <= 1'b0;
         if (tw) S_AXI_WVALID <= 1'b0;
      end while (!tb);
      check({30'h0, r}, {30'h0, er}, "write response");
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic tr, rv;
      logic [31:0] d;
      logic [1:0] r;
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do begin
         @(negedge SYS_CLK);
         tr = S_AXI_ARVALID && S_AXI_ARREADY;
         rv = S_AXI_RVALID;
         d = S_AXI_RDATA;
         r = S_AXI_RRESP;
         @(posedge SYS_CLK);
         if (tr) S_AXI_ARVALID <= 1'b0;
      end while (!rv);
      check(d, ed, "read data");
      check({30'h0, r}, {30'h0, er}, "read response");
   endtask
   task automatic pin_after(input logic e);
      repeat (12) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      check({31'h0, CPU_MASKABLE_REQUEST_PIN}, {31'h0, e}, "request pin");
      @(posedge SYS_CLK);
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // =====================================================================
   // tests
   initial begin
      repeat (4) @(posedge SYS_CLK);
      SRST <= 1'b0;
      @(posedge SYS_CLK);
      rd(IPCA_OFS_MASK, IPCA_RST_MASK, IPCA_RESP_OKAY);
      rd(IPCA_OFS_TRIGGER, IPCA_RST_TRIGGER, IPCA_RESP_OKAY);
      rd(IPCA_OFS_VECTOR_BASE, IPCA_RST_VECTOR_BASE, IPCA_RESP_OKAY);
      rd(32'h1c, 32'h0, IPCA_RESP_SLVERR);
      wr(32'h1c, 32'h1, IPCA_RESP_SLVERR);
      wr(IPCA_OFS_VECTOR_BASE, 32'h46, IPCA_RESP_OKAY);
      REQUEST_INPUTS <= 8'h04;
      pin_after(1'b0);
      wr(IPCA_OFS_MASK, 32'h0, IPCA_RESP_OKAY);
      pin_after(1'b1);
      rd(IPCA_OFS_STATUS, 32'h1, IPCA_RESP_OKAY);
      rd(IPCA_OFS_PENDING, 32'h04, IPCA_RESP_OKAY);
      cpu_u.ack_seq(4);
      check({31'h0, oe_first}, 32'h0, "bus driven on first pulse");
      check({22'h0, table_addr}, vaddr(8'h46, 3'd2), "vector table address");
      rd(IPCA_OFS_SERVICE, 32'h04, IPCA_RESP_OKAY);
      pin_after(1'b0);
      wr(IPCA_OFS_DONE, 32'h04, IPCA_RESP_OKAY);
      rd(IPCA_OFS_SERVICE, 32'h0, IPCA_RESP_OKAY);
      pin_after(1'b0);
      REQUEST_INPUTS <= 8'h00;
      pin_after(1'b0);
      REQUEST_INPUTS <= 8'h04;
      pin_after(1'b1);
      cpu_u.ack_seq(12);
      check({22'h0, table_addr}, vaddr(8'h46, 3'd2), "slow acknowledge vector");
      wr(IPCA_OFS_DONE, 32'h04, IPCA_RESP_OKAY);
      REQUEST_INPUTS <= 8'h00;
      wr(IPCA_OFS_TRIGGER, 32'h20, IPCA_RESP_OKAY);
      REQUEST_INPUTS <= 8'h20;
      pin_after(1'b1);
      cpu_u.ack_seq(4);
      check({22'h0, table_addr}, vaddr(8'h46, 3'd5), "level vector");
      rd(IPCA_OFS_SERVICE, 32'h20, IPCA_RESP_OKAY);
      pin_after(1'b0);
      wr(IPCA_OFS_DONE, 32'h20, IPCA_RESP_OKAY);
      pin_after(1'b1);
      REQUEST_INPUTS <= 8'h00;
      pin_after(1'b0);
      cpu_u.ack_seq(4);
      check({22'h0, table_addr}, vaddr(8'h46, IPCA_SPURIOUS_LEVEL), "spurious vector");
      rd(IPCA_OFS_SERVICE, 32'h0, IPCA_RESP_OKAY);
      rd(IPCA_OFS_STATUS, 32'h2, IPCA_RESP_OKAY);
      give_verdict();
   end
   initial begin
      #100000;
      $display("MISMATCH at %0t ns: watchdog expired", $time);
      err_count++;
      give_verdict();
   end
endmodule // interrupt_priority_cell_ack_tb_top
